//--- src/isc_ctrl.sv
/*
  Control part of the two-wire serial controller: control, status and
  divisor registers, interrupt gating, soft reinit and clock generation.
  Assumes the shifting engine drives the event levels on the same clock
  and flushes its FIFOs and idles itself on the reinit pulse.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - writing one to control bit 8 reinitialises; the bit clears itself
// - reinit flushes both FIFOs, clears status, idles every state machine
// - reinit keeps both divisors and every other control bit
// - bit 7 enables interrupt while transmit FIFO has room
// - bit 6 enables interrupt while receive FIFO holds data
// - bit 5 enables interrupt while receive FIFO is full
// - bit 4 enables interrupt when starved slave transmitter holds SCL low
// - bit 3 enables interrupt when starved master transmitter holds SCL low
// - bit 2 enables interrupt on missing acknowledge
// - bit 1 enables interrupt on lost arbitration
// - bit 0 enables interrupt after a STOP ends a master transfer
// - high divisor counts clock cycles of SCL high phase
// - high divisor is 8 bits, reset value 0x41
// - low divisor counts clock cycles of SCL low phase
module isc_ctrl
  import isc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // engine events and levels
  input wire logic tx_room_in,
  input wire logic rx_avail_in,
  input wire logic rx_full_in,
  input wire logic slave_starved_in,
  input wire logic master_starved_in,
  input wire logic no_ack_in,
  input wire logic arb_lost_in,
  input wire logic xfer_done_in,
  input wire logic scl_run_in,
  // engine control
  output logic reinit_out,
  // serial clock pin
  output logic scl_o_out,
  output logic scl_oe_n_out,
  // interrupt
  output logic irq_out
);

  // refused while elaborating: the divisor fields are eight bits wide
  if (DIV_W != 8) begin : g_bad_width
    $error("DIV_W must be 8 to match the divisor registers");
  end

  logic [ISC_NUM_SOURCES-1:0] irq_en;
  logic self_clearing_reinit;
  logic [DIV_W-1:0] scl_high_divisor;
  logic [DIV_W-1:0] scl_low_divisor;
  logic [ISC_NUM_SOURCES-1:0] serial_status;
  logic [ISC_NUM_SOURCES-1:0] events;
  logic [ISC_NUM_SOURCES-1:0] status_clear;
  logic wr_control;
  logic wr_status;
  logic wr_high;
  logic wr_low;
  logic [31:0] next_rdata;

  assign wr_control = wr_in && (addr_in == ISC_CONTROL_ADDR);
  assign wr_status = wr_in && (addr_in == ISC_STATUS_ADDR);
  assign wr_high = wr_in && (addr_in == ISC_HIGH_ADDR);
  assign wr_low = wr_in && (addr_in == ISC_LOW_ADDR);

  // event vector in the enable layout
  assign events[ISC_TX_ROOM_BIT] = tx_room_in;
  assign events[ISC_RX_AVAIL_BIT] = rx_avail_in;
  assign events[ISC_RX_FULL_BIT] = rx_full_in;
  assign events[ISC_SLAVE_STARVED_BIT] = slave_starved_in;
  assign events[ISC_MASTER_STARVED_BIT] = master_starved_in;
  assign events[ISC_NO_ACK_BIT] = no_ack_in;
  assign events[ISC_ARB_LOST_BIT] = arb_lost_in;
  assign events[ISC_XFER_DONE_BIT] = xfer_done_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en <= ISC_IRQ_EN_RST;
    end else if (wr_control) begin
      irq_en <= wdata_in[ISC_NUM_SOURCES-1:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      self_clearing_reinit <= 1'b0;
    end else begin
      self_clearing_reinit <= wr_control && wdata_in[ISC_REINIT_BIT];
    end
  end

  // engine flushes FIFOs and idles on this pulse
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reinit_out <= 1'b0;
    end else begin
      reinit_out <= wr_control && wdata_in[ISC_REINIT_BIT];
    end
  end

  // high divisor width and reset value
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_high_divisor <= ISC_HIGH_RST;
    end else if (wr_high) begin
      scl_high_divisor <= wdata_in[DIV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_low_divisor <= ISC_LOW_RST;
    end else if (wr_low) begin
      scl_low_divisor <= wdata_in[DIV_W-1:0];
    end
  end

  assign status_clear = wr_status ? wdata_in[ISC_NUM_SOURCES-1:0] : '0;

  // status flags, cleared by reinit
  // level sources re-set at once while their condition persists
  genvar gi;
  generate
    for (gi = 0; gi < ISC_NUM_SOURCES; gi++) begin : g_flag
      isc_flag u_flag (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .set_in(events[gi]),
        .clear_in(status_clear[gi]),
        .flush_in(self_clearing_reinit),
        .flag_out(serial_status[gi])
      );
    end
  endgenerate

  // one level interrupt from enabled flags
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(serial_status & irq_en);
    end
  end

  // read data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = ISC_RDATA_RST;
    if (rd_in) begin
      case (addr_in)
        ISC_STATUS_ADDR: next_rdata = {24'h00_0000, serial_status};
        ISC_CONTROL_ADDR: next_rdata = {23'h00_0000, self_clearing_reinit, irq_en};
        ISC_HIGH_ADDR: next_rdata = {24'h00_0000, scl_high_divisor};
        ISC_LOW_ADDR: next_rdata = {24'h00_0000, scl_low_divisor};
        default: next_rdata = ISC_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= ISC_RDATA_RST;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_o_out <= 1'b0;
    end else begin
      scl_o_out <= 1'b0;
    end
  end

  isc_scl_div #(
    .CNT_W(DIV_W)
  ) u_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .run_in(scl_run_in),
    .hold_low_in(slave_starved_in || master_starved_in),
    .idle_in(self_clearing_reinit),
    .high_count_in(scl_high_divisor),
    .low_count_in(scl_low_divisor),
    .scl_oe_n_out(scl_oe_n_out)
  );

  a_reinit_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_control && wdata_in[ISC_REINIT_BIT] |=> self_clearing_reinit ##1 !self_clearing_reinit)
    else $error("reinit bit did not self clear");

  a_reinit_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    self_clearing_reinit && (events == '0) |=> serial_status == '0)
    else $error("reinit left status set");

  a_reinit_keeps: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    self_clearing_reinit && !wr_in |=> $stable(irq_en) && $stable(scl_high_divisor)
    && $stable(scl_low_divisor))
    else $error("reinit changed settings");

  a_reinit_out_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    reinit_out == self_clearing_reinit)
    else $error("engine reinit pulse differs from control bit");

  a_reinit_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rd_in && (addr_in == ISC_CONTROL_ADDR) && self_clearing_reinit |=> rdata_out[ISC_REINIT_BIT])
    else $error("reinit bit not visible while active");

  a_no_wr_keep: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !wr_control |=> $stable(irq_en))
    else $error("enables changed without a write");

  a_reinit_idles_div: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    self_clearing_reinit |=> ##1 scl_oe_n_out)
    else $error("divider not idle after reinit");

  a_div_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !scl_run_in |=> ##1 scl_oe_n_out)
    else $error("serial clock driven while stopped");

  a_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rd_in |=> rdata_out == ISC_RDATA_RST)
    else $error("read data outside read cycle");

  a_status_w1c: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_status && ((status_clear & events) == '0) |=> (serial_status & $past(status_clear)) == '0)
    else $error("status bit not cleared by write of one");

  // interrupt path: event at N, flag after N, output one edge later
  a_tx_room_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    tx_room_in && irq_en[ISC_TX_ROOM_BIT] && !wr_control |=> ##1 irq_out)
    else $error("tx room interrupt missing");

  a_rx_avail_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rx_avail_in && irq_en[ISC_RX_AVAIL_BIT] && !wr_control |=> ##1 irq_out)
    else $error("rx data interrupt missing");

  a_rx_full_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rx_full_in && irq_en[ISC_RX_FULL_BIT] && !wr_control |=> ##1 irq_out)
    else $error("rx full interrupt missing");

  a_slave_starved_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    slave_starved_in && irq_en[ISC_SLAVE_STARVED_BIT] && !wr_control |=> ##1 irq_out)
    else $error("slave starved interrupt missing");

  a_master_starved_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    master_starved_in && irq_en[ISC_MASTER_STARVED_BIT] && !wr_control |=> ##1 irq_out)
    else $error("master starved interrupt missing");

  a_arb_lost_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    arb_lost_in && irq_en[ISC_ARB_LOST_BIT] && !wr_control |=> ##1 irq_out)
    else $error("arbitration interrupt missing");

  a_no_ack_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    no_ack_in && irq_en[ISC_NO_ACK_BIT] && !wr_control |=> ##1 irq_out)
    else $error("no ack interrupt missing");

  a_done_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    xfer_done_in && irq_en[ISC_XFER_DONE_BIT] && !wr_control |=> ##1 irq_out)
    else $error("done interrupt missing");

  a_mask_blocks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (serial_status & irq_en) == '0 |=> !irq_out)
    else $error("masked source raised interrupt");

  a_irq_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (serial_status & irq_en) != '0 |=> irq_out)
    else $error("enabled flag without interrupt");

  a_high_reset: assert property (@(posedge sys_clk_in)
    $fell(rst_in) |-> scl_high_divisor == ISC_HIGH_RST)
    else $error("high divisor reset value wrong");

endmodule
`default_nettype wire

//--- src/isc_flag.sv
/*
  One sticky status flag with write-one-to-clear and flush.
  Assumes set, clear and flush come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_flag
  import isc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // controls
  input wire logic set_in,
  input wire logic clear_in,
  input wire logic flush_in,
  // state
  output logic flag_out
);

  // a set in the clearing cycle is kept so no event is lost
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in || flush_in) begin
      flag_out <= 1'b0;
    end
  end

  a_set_wins: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    set_in |=> flag_out)
    else $error("flag lost an event");

endmodule
`default_nettype wire

//--- src/isc_pkg.sv
/*
  Shared constants for the serial controller control block: register byte
  addresses, control field positions, reset values and divider states.
  Assumes a 32-bit byte-addressed register port.
*/
package isc_pkg;

  // register byte addresses
  localparam logic [31:0] ISC_STATUS_ADDR = 32'h3102_0304;
  localparam logic [31:0] ISC_CONTROL_ADDR = 32'h3102_0308;
  localparam logic [31:0] ISC_HIGH_ADDR = 32'h3102_030C;
  localparam logic [31:0] ISC_LOW_ADDR = 32'h3102_0310;

  // control and status field positions (status shares the enable layout)
  localparam int ISC_REINIT_BIT = 8;
  localparam int ISC_TX_ROOM_BIT = 7;
  localparam int ISC_RX_AVAIL_BIT = 6;
  localparam int ISC_RX_FULL_BIT = 5;
  localparam int ISC_SLAVE_STARVED_BIT = 4;
  localparam int ISC_MASTER_STARVED_BIT = 3;
  localparam int ISC_NO_ACK_BIT = 2;
  localparam int ISC_ARB_LOST_BIT = 1;
  localparam int ISC_XFER_DONE_BIT = 0;
  localparam int ISC_NUM_SOURCES = 8;

  // values after reset
  localparam logic [7:0] ISC_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] ISC_HIGH_RST = 8'h41;
  localparam logic [7:0] ISC_LOW_RST = 8'h41;
  localparam logic [31:0] ISC_RDATA_RST = 32'h0000_0000;

  // divider phases, gray coded along idle -> high -> low
  typedef enum logic [1:0] {
    ISC_IDLE = 2'b00,
    ISC_HIGH = 2'b01,
    ISC_LOW = 2'b11
  } isc_phase_t;

endpackage

//--- src/isc_scl_div.sv
/*
  Generates the serial clock from high and low terminal counts.
  Assumes run and hold levels come from the shifting engine on the same clock.
  The pin is open drain: enable low pulls the line low.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_scl_div
  import isc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  input wire logic hold_low_in,
  input wire logic idle_in,
  input wire logic [CNT_W-1:0] high_count_in,
  input wire logic [CNT_W-1:0] low_count_in,
  // pin drive
  output logic scl_oe_n_out
);

  // refused while elaborating, before any cycle runs
  if (CNT_W < 2) begin : g_bad_width
    $error("CNT_W must be at least 2");
  end

  isc_phase_t phase;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term;
  logic last;

  // a zero count would wrap to the longest phase; it is served as one cycle
  assign term = (phase == ISC_HIGH) ? high_count_in : low_count_in;
  assign last = (term == '0) || (cnt >= term - 1'b1);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= ISC_IDLE;
      cnt <= '0;
    end else if (idle_in || !run_in) begin
      phase <= ISC_IDLE;
      cnt <= '0;
    end else begin
      case (phase)
        ISC_IDLE: begin
          phase <= ISC_HIGH;
          cnt <= '0;
        end
        ISC_HIGH: begin
          cnt <= last ? '0 : cnt + 1'b1;
          if (last) begin
            phase <= ISC_LOW;
          end
        end
        // low phase length, stretched while starved
        ISC_LOW: begin
          if (last && !hold_low_in) begin
            phase <= ISC_HIGH;
            cnt <= '0;
          end else if (!last) begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          phase <= ISC_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_oe_n_out <= 1'b1;
    end else begin
      scl_oe_n_out <= !(phase == ISC_LOW);
    end
  end

  a_high_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (phase == ISC_HIGH) && last && run_in && !idle_in && (high_count_in != '0)
    |-> cnt == high_count_in - 1'b1)
    else $error("high phase length wrong");

  a_low_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(phase) == ISC_LOW && phase == ISC_HIGH && (low_count_in != '0)
    |-> $past(cnt) == low_count_in - 1'b1)
    else $error("low phase length wrong");

endmodule
`default_nettype wire

//--- verif/isc_ctrl_test.sv
/*
  Self-checking bench of the control block with an engine model.
  Assumes the register port answers reads one cycle later and never waits.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_ctrl_test
  import isc_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:0] addr_in = 32'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic scl_run_in = 1'b0;
  logic [7:0] set_c = 8'h00;
  logic [7:0] clr_c = 8'h00;
  wire logic [7:0] ev;
  logic [31:0] rdata_out;
  logic reinit_out, scl_o_out, scl_oe_n_out, irq_out;
  int err_count = 0;
  int n_tests = 0;
  int n;
  logic [7:0] lf = 8'h5A;
  logic [7:0] en, hi, lo, bit_i;

  always #12.5 sys_clk_in = ~sys_clk_in;

  isc_ctrl u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tx_room_in(ev[7]), .rx_avail_in(ev[6]),
    .rx_full_in(ev[5]), .slave_starved_in(ev[4]), .master_starved_in(ev[3]), .no_ack_in(ev[2]),
    .arb_lost_in(ev[1]), .xfer_done_in(ev[0]), .scl_run_in(scl_run_in), .reinit_out(reinit_out),
    .scl_o_out(scl_o_out), .scl_oe_n_out(scl_oe_n_out), .irq_out(irq_out));

  isc_engine_model u_eng (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reinit_in(reinit_out),
    .set_in(set_c), .clr_in(clr_c), .ev_out(ev));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic conclude();
    $display("mismatches %0d of %0d comparisons", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    check(rdata_out, exp);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic ev_cmd(input logic [7:0] s, input logic [7:0] c);
    @(posedge sys_clk_in);
    set_c <= s;
    clr_c <= c;
    @(posedge sys_clk_in);
    set_c <= 8'h00;
    clr_c <= 8'h00;
  endtask

  // counts cycles until the pin drive reaches v; a hang ends the run
  task automatic meas(input logic v, output int k);
    k = 0;
    while (scl_oe_n_out !== v && k < 200) begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end
    if (k >= 200) begin
      err_count++;
      conclude();
    end
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rdc(ISC_CONTROL_ADDR, 32'h0);
    rdc(ISC_STATUS_ADDR, 32'h0);
    rdc(ISC_HIGH_ADDR, 32'h41);
    rdc(ISC_LOW_ADDR, 32'h41);
    wr(32'h3102_0300, 32'hFFFF_FFFF);
    rdc(32'h3102_0300, 32'h0);
    check(irq_out, 32'h0);
    lf = lfsr_next(lf);
    hi = lf;
    lf = lfsr_next(lf);
    lo = lf;
    wr(ISC_HIGH_ADDR, {24'hA5A5A5, hi});
    wr(ISC_LOW_ADDR, {24'h5A5A5A, lo});
    rdc(ISC_HIGH_ADDR, {24'h0, hi});
    rdc(ISC_LOW_ADDR, {24'h0, lo});
    // each source: masked by the others, then enabled alone, then cleared
    for (int i = 0; i < ISC_NUM_SOURCES; i++) begin
      bit_i = 8'h01 << i;
      lf = lfsr_next(lf);
      en = lf & ~bit_i;
      wr(ISC_CONTROL_ADDR, {23'h7FFFFF, 1'b0, en});
      rdc(ISC_CONTROL_ADDR, {24'h0, en});
      ev_cmd(bit_i, 8'h00);
      tick(4);
      check(irq_out, 32'h0);
      rdc(ISC_STATUS_ADDR, {24'h0, bit_i});
      wr(ISC_CONTROL_ADDR, {24'h0, bit_i});
      tick(3);
      check(irq_out, 32'h1);
      ev_cmd(8'h00, bit_i);
      wr(ISC_STATUS_ADDR, {24'h0, bit_i});
      tick(3);
      check(irq_out, 32'h0);
      rdc(ISC_STATUS_ADDR, 32'h0);
    end
    // soft reinit with every status bit set and interrupt pending
    lf = lfsr_next(lf);
    en = lf | 8'h01;
    wr(ISC_CONTROL_ADDR, {24'h0, en});
    ev_cmd(8'hFF, 8'h00);
    tick(2);
    ev_cmd(8'h00, 8'hFF);
    tick(2);
    rdc(ISC_STATUS_ADDR, 32'hFF);
    wr(ISC_CONTROL_ADDR, {23'h0, 1'b1, en});
    #1;
    check(reinit_out, 32'h1);
    tick(1);
    check(reinit_out, 32'h0);
    rdc(ISC_CONTROL_ADDR, {24'h0, en});
    rdc(ISC_STATUS_ADDR, 32'h0);
    rdc(ISC_HIGH_ADDR, {24'h0, hi});
    rdc(ISC_LOW_ADDR, {24'h0, lo});
    check(irq_out, 32'h0);
    // serial clock with a short random high phase and the shortest low phase
    lf = lfsr_next(lf);
    hi = {5'h0, lf[2:0]} + 8'h02;
    lo = 8'h01;
    wr(ISC_HIGH_ADDR, {24'h0, hi});
    wr(ISC_LOW_ADDR, {24'h0, lo});
    @(posedge sys_clk_in);
    scl_run_in <= 1'b1;
    meas(1'b0, n);
    meas(1'b1, n);
    check(n, {24'h0, lo});
    meas(1'b0, n);
    check(n, {24'h0, hi});
    check(scl_o_out, 32'h0);
    @(posedge sys_clk_in);
    scl_run_in <= 1'b0;
    tick(4);
    check(scl_oe_n_out, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire

//--- verif/isc_engine_model.sv
/*
  Behavioural model of the shifting engine beside the control block: holds
  the eight event levels that the bench commands and idles on reinit.
  Assumes set and clear commands arrive as one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_engine_model
  import isc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // commands
  input wire logic reinit_in,
  input wire logic [7:0] set_in,
  input wire logic [7:0] clr_in,
  // event levels
  output logic [7:0] ev_out
);
  // starts idle with the transmitter not yet loaded, so no source is active
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ev_out <= 8'h00;
    end else if (reinit_in) begin
      ev_out <= 8'h00;
    end else begin
      ev_out <= (ev_out | set_in) & ~clr_in;
    end
  end
endmodule
`default_nettype wire
